// File: cuil_pkg.sv
// Shared constants for the charge unit interrupt latch and its host end
package cuil_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Times in their own unit, cycle counts derived (least times round up)
  localparam int CLR_MIN_NS = 20_000;
  localparam int INT_HOLD_NS = 1_000;
  localparam int INIT_MIN_NS = 5_000_000;
  localparam int CLR_MIN_CYC = (CLR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_HOLD_CYC = (INT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC = (INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reversals per charge unit and reversals needed to show a direction change
  localparam int UNIT_REVERSALS = 1024;
  localparam int POL_REVERSALS = 2;
  localparam int CNT_W = $clog2(UNIT_REVERSALS);
  // Pin and direction encodings
  localparam logic PIN_LOW = 1'h0;
  localparam logic PIN_HIGH = 1'h1;
  localparam logic OE_DRIVE = 1'h0;
  localparam logic OE_RELEASE = 1'h1;
  localparam logic DIR_INTO_BATT = 1'h1;
  localparam logic DIR_OUT_BATT = 1'h0;
  typedef enum {HS_IDLE, HS_CLEAR, HS_WAIT_HIGH} cuil_host_state_t;
endpackage

// File: cuil_if.sv
// Pin-level link between the charge counter device and its host
`timescale 1ns/1ps
interface cuil_if;
  import cuil_pkg::*;
  logic int_o;
  logic int_oe_n;
  logic pol_o;
  logic pol_oe_n;
  logic int_n;
  logic charge_direction;
  logic irq_clear_n;
  logic power_down_n;
  // External pull-ups: a released open-drain line reads high
  assign int_n = (int_oe_n == OE_DRIVE) ? int_o : PIN_HIGH;
  assign charge_direction = (pol_oe_n == OE_DRIVE) ? pol_o : PIN_HIGH;
  modport dev (output int_o, output int_oe_n, output pol_o, output pol_oe_n,
               input irq_clear_n, input power_down_n);
  modport host (input int_n, input charge_direction,
                output irq_clear_n, output power_down_n);
endinterface

// File: cuil_dev.sv
// Device end: reversal counter, interrupt and polarity latches, open-drain pins
`timescale 1ns/1ps
module cuil_dev #(
  parameter int REV_PER_UNIT = cuil_pkg::UNIT_REVERSALS,
  parameter int INIT_CYCLES = cuil_pkg::INIT_CYC,
  parameter int CLR_CYCLES = cuil_pkg::CLR_MIN_CYC,
  parameter int HOLD_CYCLES = cuil_pkg::INT_HOLD_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  cuil_if.dev LINK,
  input wire logic REV_STROBE,
  input wire logic REV_DIR,
  output logic COUNTING,
  output logic UNIT_LOST
);
  import cuil_pkg::*;

  localparam int RW = $clog2(REV_PER_UNIT);
  localparam int IW = $clog2(INIT_CYCLES + 1);
  localparam int CW = $clog2(CLR_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [RW-1:0] REV_TOP = RW'(REV_PER_UNIT - 1);
  localparam logic [RW-1:0] REV_ZERO = '0;
  localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYCLES - 1);
  localparam logic [CW-1:0] CLR_LAST = CW'(CLR_CYCLES - 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

  if (REV_PER_UNIT < 2 || (REV_PER_UNIT & (REV_PER_UNIT - 1)) != 0) begin : g_chk_rev
    $error("REV_PER_UNIT must be a power of two of at least 2");
  end
  if (INIT_CYCLES < 1 || CLR_CYCLES < 1 || HOLD_CYCLES < 1) begin : g_chk_cyc
    $error("Cycle counts must be at least one");
  end

  // Two-flop synchronisers; the first stage feeds only the second
  logic clr_meta_q;
  logic clr_sync_q;
  logic pd_meta_q;
  logic pd_sync_q;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clr_meta_q <= PIN_HIGH;
      clr_sync_q <= PIN_HIGH;
      pd_meta_q <= PIN_LOW;
      pd_sync_q <= PIN_LOW;
    end else begin
      clr_meta_q <= LINK.irq_clear_n;
      clr_sync_q <= clr_meta_q;
      pd_meta_q <= LINK.power_down_n;
      pd_sync_q <= pd_meta_q;
    end
  end

  wire shut = (pd_sync_q == PIN_LOW);
  wire clr_low = (clr_sync_q == PIN_LOW);

  // Initialisation interval after reset or leaving shutdown
  logic [IW-1:0] init_cnt_q;
  logic ready_q;
  wire init_done = (init_cnt_q == INIT_LAST);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      init_cnt_q <= '0;
      ready_q <= 1'h0;
    end else if (shut) begin
      init_cnt_q <= '0;
      ready_q <= 1'h0;
    end else if (!ready_q) begin
      init_cnt_q <= init_done ? init_cnt_q : init_cnt_q + IW'(1);
      ready_q <= init_done;
    end
  end

  // Reversal counter: runs regardless of latch and clear state
  logic [RW-1:0] rev_cnt_q;
  wire step = ready_q && REV_STROBE;
  wire step_up = (REV_DIR == DIR_INTO_BATT);
  wire wrap_up = step && step_up && (rev_cnt_q == REV_TOP);
  wire wrap_dn = step && !step_up && (rev_cnt_q == REV_ZERO);
  wire unit_done = wrap_up || wrap_dn;
  wire [RW-1:0] rev_next = step_up ? rev_cnt_q + RW'(1) : rev_cnt_q - RW'(1);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rev_cnt_q <= '0;
    end else if (shut) begin
      rev_cnt_q <= '0;
    end else if (step) begin
      rev_cnt_q <= rev_next;
    end
  end

  // Live direction needs a run of reversals in the new direction
  logic live_dir_q;
  logic cand_dir_q;
  logic [1:0] run_q;
  wire new_dir = step && (REV_DIR != live_dir_q);
  wire same_run = (REV_DIR == cand_dir_q) && (run_q != 2'h0);
  wire [1:0] run_next = same_run ? run_q + 2'h1 : 2'h1;
  wire dir_flip = new_dir && (run_next == 2'(POL_REVERSALS));

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      live_dir_q <= DIR_OUT_BATT;
      cand_dir_q <= DIR_OUT_BATT;
      run_q <= 2'h0;
    end else if (shut) begin
      live_dir_q <= DIR_OUT_BATT;
      cand_dir_q <= DIR_OUT_BATT;
      run_q <= 2'h0;
    end else if (step) begin
      cand_dir_q <= REV_DIR;
      run_q <= (!new_dir || dir_flip) ? 2'h0 : run_next;
      if (dir_flip) begin
        live_dir_q <= REV_DIR;
      end
    end
  end

  // Clear width and minimum interrupt low time
  logic [CW-1:0] clr_cnt_q;
  logic [HW-1:0] hold_cnt_q;
  logic int_pend_q;
  logic pol_lat_q;
  wire clr_long = clr_low && (clr_cnt_q == CLR_LAST);
  wire hold_ok = !int_pend_q || (hold_cnt_q == HOLD_LAST);
  wire clr_fire = clr_long && hold_ok;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clr_cnt_q <= '0;
    end else if (!clr_low || shut) begin
      clr_cnt_q <= '0;
    end else if (!clr_long) begin
      clr_cnt_q <= clr_cnt_q + CW'(1);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hold_cnt_q <= '0;
    end else if (!int_pend_q || unit_done) begin
      hold_cnt_q <= '0;
    end else if (hold_cnt_q != HOLD_LAST) begin
      hold_cnt_q <= hold_cnt_q + HW'(1);
    end
  end

  // Latches: a new unit wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_pend_q <= 1'h0;
      pol_lat_q <= DIR_OUT_BATT;
    end else if (shut) begin
      int_pend_q <= 1'h0;
      pol_lat_q <= DIR_OUT_BATT;
    end else if (unit_done && !int_pend_q) begin
      int_pend_q <= 1'h1;
      pol_lat_q <= wrap_up ? DIR_INTO_BATT : DIR_OUT_BATT;
    end else if (unit_done && clr_fire) begin
      pol_lat_q <= wrap_up ? DIR_INTO_BATT : DIR_OUT_BATT;
    end else if (clr_fire) begin
      int_pend_q <= 1'h0;
    end
  end

  // A unit finishing while one is still pending and no clear fires is dropped and flagged
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      UNIT_LOST <= 1'h0;
    end else begin
      UNIT_LOST <= unit_done && int_pend_q && !clr_fire;
    end
  end

  // Open-drain pins: value is always low, only the enable moves
  wire pol_level = int_pend_q ? pol_lat_q : live_dir_q;
  logic int_oe_n_q;
  logic pol_oe_n_q;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_oe_n_q <= OE_RELEASE;
      pol_oe_n_q <= OE_RELEASE;
    end else if (shut || !ready_q) begin
      int_oe_n_q <= OE_RELEASE;
      pol_oe_n_q <= OE_RELEASE;
    end else begin
      int_oe_n_q <= int_pend_q ? OE_DRIVE : OE_RELEASE;
      pol_oe_n_q <= (pol_level == DIR_INTO_BATT) ? OE_RELEASE : OE_DRIVE;
    end
  end

  assign LINK.int_o = PIN_LOW;
  assign LINK.pol_o = PIN_LOW;
  assign LINK.int_oe_n = int_oe_n_q;
  assign LINK.pol_oe_n = pol_oe_n_q;
  assign COUNTING = ready_q;
endmodule

// File: cuil_host.sv
// Host end: services charge interrupts, drives clear and shutdown
`timescale 1ns/1ps
module cuil_host #(
  parameter int CLR_CYCLES = cuil_pkg::CLR_MIN_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  cuil_if.host LINK,
  input wire logic ENABLE,
  input wire logic AUTO_CLEAR,
  input wire logic BATT_PRESENT,
  output logic UNIT_VALID,
  output logic UNIT_CHARGE,
  output logic BUSY
);
  import cuil_pkg::*;

  localparam int CW = $clog2(CLR_CYCLES + 1);
  localparam logic [CW-1:0] CLR_LAST = CW'(CLR_CYCLES - 1);

  if (CLR_CYCLES < 1) begin : g_chk
    $error("CLR_CYCLES must be at least one");
  end

  cuil_host_state_t state_q;
  cuil_host_state_t state_d;
  logic [CW-1:0] cnt_q;
  logic int_prev_q;
  logic pd_q;
  logic clr_q;

  // Pins are untrusted while the battery is out
  wire pins_ok = BATT_PRESENT && pd_q;
  wire int_fall = pins_ok && (int_prev_q == PIN_HIGH) && (LINK.int_n == PIN_LOW);
  wire int_high = (LINK.int_n == PIN_HIGH);
  wire cnt_done = (cnt_q == CLR_LAST);

  always_comb begin
    state_d = state_q;
    case (state_q)
      HS_IDLE: begin
        if (int_fall && !AUTO_CLEAR) begin
          state_d = HS_CLEAR;
        end
      end
      HS_CLEAR: begin
        if (cnt_done) begin
          state_d = HS_WAIT_HIGH;
        end
      end
      HS_WAIT_HIGH: begin
        if (int_high || !pins_ok) begin
          state_d = HS_IDLE;
        end
      end
      default: state_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= HS_IDLE;
      cnt_q <= '0;
      int_prev_q <= PIN_HIGH;
      pd_q <= PIN_LOW;
      clr_q <= PIN_HIGH;
      UNIT_VALID <= 1'h0;
      UNIT_CHARGE <= DIR_OUT_BATT;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == HS_CLEAR && !cnt_done) ? cnt_q + CW'(1) : '0;
      int_prev_q <= LINK.int_n;
      pd_q <= ENABLE;
      clr_q <= (state_d == HS_CLEAR) ? PIN_LOW : PIN_HIGH;
      UNIT_VALID <= int_fall;
      if (int_fall) begin
        UNIT_CHARGE <= LINK.charge_direction;
      end
    end
  end

  // In autonomous mode the interrupt line is wired straight to clear
  assign LINK.irq_clear_n = AUTO_CLEAR ? LINK.int_n : clr_q;
  assign LINK.power_down_n = pd_q;
  assign BUSY = (state_q != HS_IDLE);
endmodule

// File: cuil_monitor.sv
// Concurrent checks on the pin-level link between device and host
`timescale 1ns/1ps
module cuil_monitor #(
  parameter int CLEAR_CYCLES = 200
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic int_o,
  input wire logic int_oe_n,
  input wire logic pol_o,
  input wire logic pol_oe_n,
  input wire logic int_n,
  input wire logic irq_clear_n,
  input wire logic power_down_n
);
  import cuil_pkg::*;
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic prev_q;
  logic [5:0] hist_q;
  logic clear_hi;
  // Length of the latest low run of the clear line, kept after it rises
  assign run_d = prev_q ? 16'h0001 : run_q + {15'h0000, run_q != 16'hffff};
  // Clear high long enough that no clear can still sit in the synchroniser
  assign clear_hi = (&hist_q) && irq_clear_n;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q <= 16'h0000;
      prev_q <= 1'h1;
      hist_q <= 6'h3f;
    end else begin
      prev_q <= irq_clear_n;
      hist_q <= {hist_q[4:0], irq_clear_n};
      if (!irq_clear_n) begin
        run_q <= run_d;
      end
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_low_hold;
    !int_n [*8] ##1 !int_n ##1 !int_n;
  endsequence
  sequence s_quiet;
    (int_oe_n == OE_RELEASE && pol_oe_n == OE_RELEASE) [*8] ##1
    (int_oe_n == OE_RELEASE && pol_oe_n == OE_RELEASE) [*8];
  endsequence
  a_int_open_drain: assert property (int_oe_n == OE_DRIVE |-> int_o == PIN_LOW)
    else $error("Interrupt pin driven high");
  a_dir_open_drain: assert property (pol_oe_n == OE_DRIVE |-> pol_o == PIN_LOW)
    else $error("Direction pin driven high");
  a_shutdown_release: assert property (!power_down_n [*5] |-> int_oe_n && pol_oe_n)
    else $error("Pins not released in shutdown");
  a_clear_width: assert property (disable iff (!RST_B || !power_down_n)
    $rose(int_oe_n) |-> run_q >= CLEAR_CYCLES)
    else $error("Interrupt released by a short clear");
  a_auto_hold: assert property (disable iff (!RST_B || !power_down_n) $fell(int_n) |-> s_low_hold)
    else $error("Interrupt low pulse too short");
  a_dir_latched: assert property (int_oe_n == OE_DRIVE && $past(int_oe_n) == OE_DRIVE && clear_hi
    |-> $stable(pol_oe_n))
    else $error("Direction changed while latched");
  a_init_quiet: assert property ($rose(power_down_n) |-> s_quiet)
    else $error("Pins active during initialisation");
  a_dir_filter: assert property (int_oe_n == OE_RELEASE && $past(int_oe_n) == OE_RELEASE
    && $changed(pol_oe_n) |=> $stable(pol_oe_n))
    else $error("Direction changed on one reversal");
endmodule

// File: testbench.sv
// Testbench joining device and host ends over the pin-level link
`timescale 1ns/1ps
module testbench;
  import cuil_pkg::*;
  localparam int INIT = 20;
  logic clk, rst_b, rev_strobe, rev_dir, enable, auto_clear, batt_present;
  logic counting, unit_lost, unit_valid, unit_charge;
  int n_mismatch, checks, n_valid, n_lost, n;
  cuil_if i_cuil_if();
  wire logic int_pin = i_cuil_if.int_n;
  wire logic dir_pin = i_cuil_if.charge_direction;
  // Short unit and init counts keep the run brief
  cuil_dev #(.REV_PER_UNIT(8), .INIT_CYCLES(INIT)) i_cuil_dev (.SYS_CLK(clk), .RST_B(rst_b),
    .LINK(i_cuil_if), .REV_STROBE(rev_strobe), .REV_DIR(rev_dir), .COUNTING(counting), .UNIT_LOST(unit_lost));
  cuil_host i_cuil_host (.SYS_CLK(clk), .RST_B(rst_b), .LINK(i_cuil_if), .ENABLE(enable),
    .AUTO_CLEAR(auto_clear), .BATT_PRESENT(batt_present), .UNIT_VALID(unit_valid),
    .UNIT_CHARGE(unit_charge), .BUSY());
  cuil_monitor #(.CLEAR_CYCLES(CLR_MIN_CYC)) i_cuil_monitor (.SYS_CLK(clk), .RST_B(rst_b),
    .int_o(i_cuil_if.int_o), .int_oe_n(i_cuil_if.int_oe_n), .pol_o(i_cuil_if.pol_o),
    .pol_oe_n(i_cuil_if.pol_oe_n), .int_n(i_cuil_if.int_n), .irq_clear_n(i_cuil_if.irq_clear_n),
    .power_down_n(i_cuil_if.power_down_n));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (unit_valid === 1'h1) n_valid++;
    if (unit_lost === 1'h1) n_lost++;
  end
  task finish_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task strobe(input logic dir, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      rev_strobe <= 1'h1;
      rev_dir <= dir;
    end
    @(posedge clk);
    rev_strobe <= 1'h0;
  endtask
  task wait_int(input logic lvl);
    n = 0;
    while (int_pin !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask
  task wait_count;
    n = 0;
    while (counting !== 1'h1) begin
      @(negedge clk);
      n++;
      if (n > 100) begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask
  task idle(input int cnt);
    repeat (cnt) @(negedge clk);
  endtask
  task t_start;
    wait_count();
    check(n >= INIT, 1'h1);
    idle(2);
    check(dir_pin, DIR_OUT_BATT);
  endtask
  task t_up;
    strobe(1'h1, 1);
    idle(3);
    check(dir_pin, DIR_OUT_BATT);
    strobe(1'h1, 1);
    idle(3);
    check(dir_pin, DIR_INTO_BATT);
    strobe(1'h1, 5);
    idle(4);
    check(int_pin, PIN_HIGH);
    strobe(1'h1, 1);
    wait_int(PIN_LOW);
    check(n <= 3, 1'h1);
    check(dir_pin, DIR_INTO_BATT);
    wait_int(PIN_HIGH);
    check(n >= CLR_MIN_CYC, 1'h1);
    check(unit_charge, DIR_INTO_BATT);
    check(n_valid, 1);
  endtask
  task t_lost;
    strobe(1'h0, 1);
    wait_int(PIN_LOW);
    check(dir_pin, DIR_OUT_BATT);
    strobe(1'h1, 1);
    idle(3);
    check(n_lost, 1);
    check(unit_charge, DIR_OUT_BATT);
    check(dir_pin, DIR_OUT_BATT);
    wait_int(PIN_HIGH);
    idle(2);
    check(dir_pin, DIR_INTO_BATT);
    strobe(1'h0, 1);
    wait_int(PIN_LOW);
    check(n <= 3, 1'h1);
    wait_int(PIN_HIGH);
  endtask
  task t_auto;
    @(posedge clk);
    auto_clear <= 1'h1;
    strobe(1'h1, 1);
    wait_int(PIN_LOW);
    wait_int(PIN_HIGH);
    check(n >= INT_HOLD_CYC, 1'h1);
    check(n_valid, 4);
    @(posedge clk);
    auto_clear <= 1'h0;
  endtask
  task t_shutdown;
    @(posedge clk);
    batt_present <= 1'h0;
    strobe(1'h0, 3);
    idle(4);
    check(n_valid, 4);
    @(posedge clk);
    enable <= 1'h0;
    wait_int(PIN_HIGH);
    check(n <= 6, 1'h1);
    idle(2);
    check(counting, 1'h0);
    @(posedge clk);
    enable <= 1'h1;
    batt_present <= 1'h1;
    wait_count();
    check(n >= INIT, 1'h1);
    strobe(1'h0, 1);
    wait_int(PIN_LOW);
    check(n <= 3, 1'h1);
    wait_int(PIN_HIGH);
  endtask
  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    rev_strobe = 1'h0;
    rev_dir = 1'h0;
    enable = 1'h0;
    auto_clear = 1'h0;
    batt_present = 1'h1;
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    enable <= 1'h1;
    t_start();
    t_up();
    t_lost();
    t_auto();
    t_shutdown();
    finish_test();
  end
endmodule
